// >>> include/cfg_slice_pkg.sv
// Constants and carriers for the configuration header slice 0x2C-0x3B.
// Assumes a host-side front end that turns configuration cycles into
// one-cycle dword requests on the device clock.
package cfg_slice_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] OFS_SUBSYS_IDENT = 8'h2C;
	localparam logic [7:0] OFS_ROM_BASE     = 8'h30;
	localparam logic [7:0] OFS_CAPABILITY_LIST_POINTER      = 8'h34;
	localparam logic [7:0] OFS_RSVD_38      = 8'h38;

	// ------------------------------------------------------------
	// Fields and values
	// ------------------------------------------------------------
	localparam int         ROM_BASE_LSB     = 22;
	localparam int         ROM_BASE_W       = 10;
	localparam int         ROM_DECODE_BIT   = 0;
	localparam int         IMAGE_ADDR_W     = 16;
	localparam logic [7:0] CAPABILITY_LIST_POINTER_AGP      = 8'h44;
	localparam logic [7:0] ROM_IDENT_FIRST  = 8'h54;
	localparam logic [1:0] ROM_IDENT_LAST   = 2'h3;
	localparam logic [9:0] ROM_BASE_RESET   = 10'h000;
	localparam logic       ROM_DECODE_RESET = 1'b0;
	localparam logic [31:0] IDENT_RESET     = 32'h00000000;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic        sel;
		logic        write;
		logic [7:0]  addr;
		logic [3:0]  byteEn;
		logic [31:0] wrData;
	} cfg_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] rdData;
	} cfg_rsp_t;

	typedef struct packed {
		logic        claim;
		logic [15:0] imageAddr;
	} rom_hit_t;

endpackage

// >>> logic/rom_ident_fetch.sv
// Fetches the four subsystem identification bytes from the boot ROM.
// Assumes a ROM port that returns data one cycle after the read strobe.
`timescale 1ns/1ps
module rom_ident_fetch (
	input  wire logic        sys_clk,
	input  wire logic        rstn,
	input  wire logic        start,
	output logic             romRdEn,
	output logic [7:0]       romAddr,
	input  wire logic [7:0]  romRdData,
	output logic [31:0]      fetchedIdent,
	output logic             fetchDone
);
	typedef enum logic [1:0] {F_IDLE, F_ISSUE, F_CAPTURE, F_DONE} fetch_state_t;

	fetch_state_t state_ff;
	fetch_state_t nxt_state;
	logic [1:0]   byteIdx_ff;
	logic [31:0]  ident_ff;

	// ------------------------------------------------------------
	// Sequencing
	// ------------------------------------------------------------
	assign romRdEn      = (state_ff == F_ISSUE);
	assign romAddr      = cfg_slice_pkg::ROM_IDENT_FIRST + {6'h00, byteIdx_ff};
	assign fetchedIdent = ident_ff;
	assign fetchDone    = (state_ff == F_DONE);

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			F_IDLE:    if (start) nxt_state = F_ISSUE;
			F_ISSUE:   nxt_state = F_CAPTURE;
			F_CAPTURE: nxt_state = (byteIdx_ff == cfg_slice_pkg::ROM_IDENT_LAST) ? F_DONE : F_ISSUE;
			F_DONE:    nxt_state = F_DONE;
		endcase
	end

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff   <= F_IDLE;
			byteIdx_ff <= 2'h0;
			ident_ff   <= cfg_slice_pkg::IDENT_RESET;
		end else begin
			state_ff <= nxt_state;
			if (state_ff == F_CAPTURE) begin
				// Lowest ROM byte lands in the lowest byte of the word
				ident_ff[byteIdx_ff*8 +: 8] <= romRdData;
				byteIdx_ff                  <= byteIdx_ff + 2'h1;
			end
		end
	end

endmodule

// >>> logic/pci_config_rom_cap_regs.sv
// Configuration header slice 0x2C-0x3B: subsystem identification,
// expansion ROM base with its decoder, capabilities pointer, reserved word.
// Assumes a front end that delivers configuration cycles as one-cycle
// dword requests and expects a registered answer one cycle later.
`timescale 1ns/1ps
module pci_config_rom_cap_regs (
	input  wire logic                     sys_clk,
	input  wire logic                     rstn,
	input  wire cfg_slice_pkg::cfg_req_t  cfgReq,
	output cfg_slice_pkg::cfg_rsp_t       cfgRsp,
	input  wire logic                     strapRomIdent,
	input  wire logic                     strapAgp,
	input  wire logic [31:0]              aliasIdent,
	output logic                          romRdEn,
	output logic [7:0]                    romAddr,
	input  wire logic [7:0]               romRdData,
	output logic                          identReady,
	input  wire logic                     memSpaceEn,
	input  wire logic                     memReqValid,
	input  wire logic [31:0]              memReqAddr,
	output cfg_slice_pkg::rom_hit_t       romHit
);
	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic        strapTaken_ff;
	logic        strapRomIdent_ff;
	logic        strapAgp_ff;
	logic        fetchStart_ff;
	logic [9:0]  romBase_ff;
	logic        romDecode_ff;
	logic        ack_ff;
	logic [31:0] rdData_ff;
	logic        claim_ff;
	logic [15:0] imageAddr_ff;

	logic [31:0] fetchedIdent;
	logic        fetchDone;

	// ------------------------------------------------------------
	// Strap capture
	// ------------------------------------------------------------
	// An async reset may only load constants, so the straps are caught on
	// the first clock after release; the fetch starts one cycle later.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			strapTaken_ff    <= 1'b0;
			strapRomIdent_ff <= 1'b0;
			strapAgp_ff      <= 1'b0;
			fetchStart_ff    <= 1'b0;
		end else begin
			fetchStart_ff <= 1'b0;
			if (!strapTaken_ff) begin
				strapTaken_ff    <= 1'b1;
				strapRomIdent_ff <= strapRomIdent;
				strapAgp_ff      <= strapAgp;
				fetchStart_ff    <= strapRomIdent;
			end
		end
	end

	rom_ident_fetch u_fetch (
		.sys_clk      (sys_clk),
		.rstn         (rstn),
		.start        (fetchStart_ff),
		.romRdEn      (romRdEn),
		.romAddr      (romAddr),
		.romRdData    (romRdData),
		.fetchedIdent (fetchedIdent),
		.fetchDone    (fetchDone)
	);

	// ------------------------------------------------------------
	// Subsystem identification source
	// ------------------------------------------------------------
	// The word is never a write target here; only its source is steered.
	wire [31:0] subsysWord = strapRomIdent_ff ? fetchedIdent : aliasIdent;

	// Ready once straps are in and, when loading from ROM, the fetch is over.
	assign identReady = strapTaken_ff && (!strapRomIdent_ff || fetchDone);

	// ------------------------------------------------------------
	// Address decode of configuration requests
	// ------------------------------------------------------------
	wire hitSubsys = (cfgReq.addr[7:2] == cfg_slice_pkg::OFS_SUBSYS_IDENT[7:2]);
	wire hitRomBase = (cfgReq.addr[7:2] == cfg_slice_pkg::OFS_ROM_BASE[7:2]);
	wire hitCapPtr = (cfgReq.addr[7:2] == cfg_slice_pkg::OFS_CAPABILITY_LIST_POINTER[7:2]);
	wire hitRsvd38 = (cfgReq.addr[7:2] == cfg_slice_pkg::OFS_RSVD_38[7:2]);
	wire anyHit = hitSubsys | hitRomBase | hitCapPtr | hitRsvd38;
	wire wrRomBase = cfgReq.sel && cfgReq.write && hitRomBase;
	wire rdTake = cfgReq.sel && !cfgReq.write;

	// ------------------------------------------------------------
	// Read data assembly
	// ------------------------------------------------------------
	wire [31:0] romBaseWord = {romBase_ff,
		11'h000,
		10'h000,
		romDecode_ff};
	// Straps are caught on the first edge after release, and a read may land
	// on that same edge, so the pin itself answers until the capture is in.
	wire agpNow = strapTaken_ff ? strapAgp_ff : strapAgp;
	wire [7:0] capPtr = agpNow ? cfg_slice_pkg::CAPABILITY_LIST_POINTER_AGP : 8'h00;
	wire [31:0] capWord = {24'h000000, capPtr};

	// Offsets outside the slice read zero, as does the reserved word.
	wire [31:0] rdMux = hitSubsys  ? subsysWord  :
		hitRomBase ? romBaseWord :
		hitCapPtr  ? capWord     :
		32'h00000000;

	// ------------------------------------------------------------
	// Configuration registers
	// ------------------------------------------------------------
	// Only the ROM base dword takes writes; all else in the slice drops them.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			romBase_ff   <= cfg_slice_pkg::ROM_BASE_RESET;
			romDecode_ff <= cfg_slice_pkg::ROM_DECODE_RESET;
		end else if (wrRomBase) begin
			if (cfgReq.byteEn[3]) romBase_ff[9:2] <= cfgReq.wrData[31:24];
			if (cfgReq.byteEn[2]) romBase_ff[1:0] <= cfgReq.wrData[23:22];
			if (cfgReq.byteEn[0]) romDecode_ff    <= cfgReq.wrData[0];
		end
	end

	// Every request is answered one cycle later, writes and unmapped ones too.
	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ack_ff    <= 1'b0;
			rdData_ff <= 32'h00000000;
		end else begin
			ack_ff <= cfgReq.sel;
			if (rdTake) rdData_ff <= anyHit ? rdMux : 32'h00000000;
		end
	end

	assign cfgRsp.ack    = ack_ff;
	assign cfgRsp.rdData = rdData_ff;

	// ------------------------------------------------------------
	// Expansion ROM decoder
	// ------------------------------------------------------------
	// The whole 4 MByte window is claimed; only its lowest 64 KByte hold
	// the image, so the offset is cut to the image width and aliases above.
	wire inWindow = (memReqAddr[31:cfg_slice_pkg::ROM_BASE_LSB] == romBase_ff);
	wire claimNow = memReqValid && romDecode_ff && memSpaceEn && inWindow;

	always_ff @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			claim_ff     <= 1'b0;
			imageAddr_ff <= 16'h0000;
		end else begin
			claim_ff <= claimNow;
			if (claimNow) imageAddr_ff <= memReqAddr[cfg_slice_pkg::IMAGE_ADDR_W-1:0];
		end
	end

	assign romHit.claim     = claim_ff;
	assign romHit.imageAddr = imageAddr_ff;

endmodule

// >>> bench/cfg_slice_monitor.sv
// Checker for the configuration slice 0x2C-0x3B.
// Assumes it is bound to the slice top and sees only its ports.
`timescale 1ns/1ps
module cfg_slice_monitor (
	input wire logic                    sys_clk,
	input wire logic                    rstn,
	input wire cfg_slice_pkg::cfg_req_t cfgReq,
	input wire cfg_slice_pkg::cfg_rsp_t cfgRsp,
	input wire logic                    strapRomIdent,
	input wire logic                    strapAgp,
	input wire logic [31:0]             aliasIdent,
	input wire logic                    romRdEn,
	input wire logic [7:0]              romAddr,
	input wire logic                    memSpaceEn,
	input wire logic                    memReqValid,
	input wire logic [31:0]             memReqAddr,
	input wire cfg_slice_pkg::rom_hit_t romHit
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	sequence rdAt(logic [7:0] a);
		cfgReq.sel && !cfgReq.write && cfgReq.addr == a;
	endsequence
	ack_follows_a: assert property (cfgReq.sel |=> cfgRsp.ack)
		else $error("request not answered");
	cap_value_a: assert property (rdAt(8'h34) |=>
		cfgRsp.rdData == (strapAgp ? 32'h44 : 32'h0))
		else $error("capability pointer wrong");
	rsvd_zero_a: assert property (rdAt(8'h38) |=> cfgRsp.rdData == 32'h0)
		else $error("reserved word not zero");
	rom_low_a: assert property (rdAt(8'h30) |=> cfgRsp.rdData[21:1] == 21'h0)
		else $error("rom base low bits set");
	alias_mirror_a: assert property (rdAt(8'h2C) ##0 !strapRomIdent |=>
		cfgRsp.rdData == $past(aliasIdent))
		else $error("ident not mirroring alias");
	claim_cause_a: assert property (romHit.claim |->
		$past(memReqValid) && $past(memSpaceEn))
		else $error("claim without enables");
	image_addr_a: assert property (romHit.claim |->
		romHit.imageAddr == 16'($past(memReqAddr)))
		else $error("image address wrong");
	rom_strobe_a: assert property (romRdEn |->
		(romAddr inside {[8'h54:8'h57]}) ##1 !romRdEn)
		else $error("rom fetch strobe wrong");
endmodule
bind pci_config_rom_cap_regs cfg_slice_monitor chk_u (.sys_clk, .rstn, .cfgReq, .cfgRsp,
	.strapRomIdent, .strapAgp, .aliasIdent, .romRdEn, .romAddr, .memSpaceEn, .memReqValid,
	.memReqAddr, .romHit);

// >>> bench/boot_rom_model.sv
// Boot ROM stand-in serving the identification fetch.
// Assumes one strobe per byte; data must hold the cycle after it.
`timescale 1ns/1ps
module boot_rom_model (
	input wire logic       sys_clk,
	input wire logic       romRdEn,
	input wire logic [7:0] romAddr,
	output logic     [7:0] romRdData
);
	logic       loaded_ff = 1'b0;
	logic [7:0] data_ff   = 8'h00;
	assign romRdData = data_ff;
	// Pins wander between reads so a mistimed capture shows up
	always @(posedge sys_clk) begin
		loaded_ff <= romRdEn;
		if (romRdEn) data_ff <= romAddr ^ 8'h5A;
		else if (!loaded_ff) data_ff <= ~data_ff;
	end
endmodule

// >>> bench/pci_config_rom_cap_regs_tb.sv
// Self-checking bench for the configuration slice 0x2C-0x3B.
// Assumes the slice answers one cycle after each request.
`timescale 1ns/1ps
module pci_config_rom_cap_regs_tb;
	logic sys_clk = 0, rstn = 0, strapRomIdent = 1, strapAgp = 1;
	logic memSpaceEn = 0, memReqValid = 0, romRdEn, identReady;
	logic [31:0] aliasIdent = 0, memReqAddr = 0, romReg, exp, d, a;
	logic [7:0] romAddr, romRdData;
	logic [3:0] b;
	cfg_slice_pkg::cfg_req_t cfgReq = '0;
	cfg_slice_pkg::cfg_rsp_t cfgRsp;
	cfg_slice_pkg::rom_hit_t romHit;
	int failCount = 0, testsRun = 0, cyc = 0;
	pci_config_rom_cap_regs dut_u (.sys_clk, .rstn, .cfgReq, .cfgRsp, .strapRomIdent,
		.strapAgp, .aliasIdent, .romRdEn, .romAddr, .romRdData, .identReady, .memSpaceEn,
		.memReqValid, .memReqAddr, .romHit);
	boot_rom_model rom_u (.sys_clk, .romRdEn, .romAddr, .romRdData);
	initial forever #50 sys_clk = ~sys_clk;
	// ------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------
	task check(input string n, input logic [31:0] seen, input logic [31:0] e);
		testsRun++;
		if (seen !== e) begin
			failCount++;
			$display("Error %s expected %h seen %h", n, e, seen);
		end
	endtask
	task wrapUp;
		if (failCount == 0 && testsRun > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task cfg(input logic w, input logic [7:0] ad, input logic [3:0] be, input logic [31:0] wd);
		@(posedge sys_clk);
		#1 cfgReq = '{1'b1, w, ad, be, wd};
		@(posedge sys_clk);
		#1 cfgReq.sel = 1'b0;
		check("ack", {31'h0, cfgRsp.ack}, 32'h1);
	endtask
	task rd(input logic [7:0] ad, input logic [31:0] e);
		cfg(1'b0, ad, 4'hF, 32'h0);
		check("rdData", cfgRsp.rdData, e);
	endtask
	task wrRom(input logic [3:0] be, input logic [31:0] wd);
		cfg(1'b1, 8'h30, be, wd);
		if (be[3]) romReg[31:24] = wd[31:24];
		if (be[2]) romReg[23:22] = wd[23:22];
		if (be[0]) romReg[0] = wd[0];
	endtask
	task reset(input logic ri, input logic ag);
		rstn = 0;
		strapRomIdent = ri;
		strapAgp = ag;
		aliasIdent = ri ? 32'h00000000 : $urandom;
		romReg = 32'h0;
		repeat (6) @(posedge sys_clk);
		#1 rstn = 1;
		repeat (12) @(posedge sys_clk);
		#1 check("identReady", {31'h0, identReady}, 32'h1);
	endtask
	// ------------------------------------------------------------
	// Sequence
	// ------------------------------------------------------------
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 4000) begin
			failCount++;
			wrapUp;
		end
	end
	initial begin
		void'($urandom(32'h5EE55F50));
		reset(1'b1, 1'b1);
		exp = 32'h57565554 ^ 32'h5A5A5A5A;
		rd(8'h2C, exp);
		cfg(1'b1, 8'h2C, 4'hF, 32'hFFFFFFFF);
		rd(8'h2C, exp);
		cfg(1'b1, 8'h34, 4'hF, 32'hFFFFFFFF);
		rd(8'h34, 32'h44);
		cfg(1'b1, 8'h38, 4'hF, 32'hFFFFFFFF);
		rd(8'h38, 32'h0);
		rd(8'h3C, 32'h0);
		rd(8'h30, 32'h0);
		repeat (10) begin
			b = 4'($urandom);
			d = $urandom;
			wrRom(b, d);
			rd(8'h30, romReg);
		end
		for (int k = 0; k < 8; k++) begin
			d = $urandom;
			memSpaceEn = k[0];
			wrRom(4'hF, {d[31:1], k[1]});
			a = {romReg[31:22] ^ {9'h0, ~k[2]}, d[21:0]};
			@(posedge sys_clk);
			#1 memReqValid = 1;
			memReqAddr = a;
			@(posedge sys_clk);
			#1 memReqValid = 0;
			check("claim", {31'h0, romHit.claim}, {31'h0, k == 7});
			if (k == 7) check("imageAddr", {16'h0, romHit.imageAddr}, {16'h0, a[15:0]});
		end
		reset(1'b0, 1'b0);
		rd(8'h2C, aliasIdent);
		rd(8'h34, 32'h0);
		rd(8'h30, 32'h0);
		wrapUp;
	end
endmodule
